// [src/dac_power_state_and_volume.sv]
/*
  power state sequencer and per-channel digital gain for the stereo dac.
  assumes register writes arrive as one-cycle strobes from the serial control
  interface, audio samples arrive one pair per sample period with valid/ready,
  and mclk_seen toggles whenever the master clock runs.
*/
`timescale 1ns/10ps
`default_nettype none
module dac_power_state_and_volume
  import dac_pwr_vol_pkg::*;
#(
  parameter int SAMPLE_W = 24,
  parameter int FIFO_DEPTH = 8,
  parameter int ZC_TIMEOUT = ZC_TIMEOUT_SAMPLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_idx,
  input wire logic [9:0] reg_wdata,
  output logic [9:0] reg_rdata,
  input wire logic i2c_mode,
  // master clock activity marker (toggles while the clock runs)
  input wire logic mclk_seen,
  // audio input
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [SAMPLE_W-1:0] smp_left,
  input wire logic [SAMPLE_W-1:0] smp_right,
  // audio output, samples passed unscaled, with the attenuation in force
  output logic out_valid,
  output logic [SAMPLE_W-1:0] out_left,
  output logic [SAMPLE_W-1:0] out_right,
  output logic [9:0] left_atten,
  output logic [9:0] right_atten,
  // power controls to analogue
  output logic clocks_en,
  output logic charge_pump_en,
  output logic [NUM_BLOCKS-1:0] block_en,
  output logic soft_mute,
  output logic [1:0] power_state
);
  localparam int FW = 2 * SAMPLE_W;
  localparam int ZW = $clog2(ZC_TIMEOUT + 1);

  // registers
  logic [1:0] power_state_sel_r;     // requested power state
  logic gain_decrease_ramp_en_r;
  logic gain_increase_ramp_en_r;
  logic zero_cross_gate_en_r;
  logic [8:0] left_gain_code_r;      // stored, not yet applied
  logic [8:0] right_gain_code_r;
  logic [8:0] left_tgt_r;            // applied targets
  logic [8:0] right_tgt_r;

  // power sequencer state
  logic [1:0] cur_r;                 // settled or transitional power state
  logic [$clog2(NUM_BLOCKS+1)-1:0] blk_cnt_r; // blocks powered so far
  logic [7:0] stage_r;               // per-stage delay
  logic [9:0] loss_r;                // master clock loss counter
  logic mclk_q_r;
  logic mclk_ok_r;
  logic mclk_ok;
  logic cfg_done;
  pwr_sel_t tgt;

  // gain engine
  logic [9:0] l_att_r;               // current attenuation, 0.125dB units
  logic [9:0] r_att_r;
  logic [ZW-1:0] zc_cnt_r;
  logic [SAMPLE_W-1:0] prev_l_r;
  logic [SAMPLE_W-1:0] prev_r_r;
  logic [9:0] l_goal;
  logic [9:0] r_goal;
  logic [9:0] mute_att;
  logic zc_hit;
  logic zc_force;

  // fifo plumbing
  logic f_valid;
  logic f_ready;
  logic [FW-1:0] f_data;
  logic [SAMPLE_W-1:0] s_l;
  logic [SAMPLE_W-1:0] s_r;

  sample_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .in_data({smp_left, smp_right}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );
  assign s_l = f_data[FW-1:SAMPLE_W];
  assign s_r = f_data[SAMPLE_W-1:0];
  // samples drain only while the signal path is powered; else back-pressure
  assign f_ready = cfg_done;

  // power state register
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      power_state_sel_r <= PSEL_RST; // R1 R5
    end else if (reg_wr && reg_idx == PWR_CTRL_IDX) begin
      power_state_sel_r <= reg_wdata[PSEL_LSB +: 2]; // R1
    end
  end

  // volume mode register
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      gain_decrease_ramp_en_r <= CTRL3_RST[DEC_RAMP_BIT]; // R17
      gain_increase_ramp_en_r <= CTRL3_RST[INC_RAMP_BIT]; // R16
      zero_cross_gate_en_r <= CTRL3_RST[ZC_BIT];
    end else if (reg_wr && reg_idx == CTRL3_IDX) begin
      gain_decrease_ramp_en_r <= reg_wdata[DEC_RAMP_BIT]; // R17
      gain_increase_ramp_en_r <= reg_wdata[INC_RAMP_BIT]; // R16
      zero_cross_gate_en_r <= reg_wdata[ZC_BIT]; // R20
    end
  end

  // gain registers; apply bit copies both stored codes to the targets at once
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      left_gain_code_r <= GAIN_RST; // R12
      right_gain_code_r <= GAIN_RST; // R12
      left_tgt_r <= GAIN_RST;
      right_tgt_r <= GAIN_RST;
    end else if (reg_wr && i2c_mode) begin // R15
      if (reg_idx == LGAIN_IDX) begin
        left_gain_code_r <= reg_wdata[8:0];
        if (reg_wdata[APPLY_BIT]) begin
          left_tgt_r <= reg_wdata[8:0]; // R14
          right_tgt_r <= right_gain_code_r; // R14
        end
      end else if (reg_idx == RGAIN_IDX) begin
        right_gain_code_r <= reg_wdata[8:0];
        if (reg_wdata[APPLY_BIT]) begin
          right_tgt_r <= reg_wdata[8:0]; // R14
          left_tgt_r <= left_gain_code_r; // R14
        end
      end
    end
  end

  // read back; apply bit is a strobe and reads zero
  always_comb begin
    reg_rdata = 10'h000;
    if (reg_rd) begin
      case (reg_idx)
        PWR_CTRL_IDX: reg_rdata = {8'h00, power_state_sel_r};
        CTRL3_IDX: reg_rdata = {5'h00, zero_cross_gate_en_r, 2'h0,
                                gain_increase_ramp_en_r, gain_decrease_ramp_en_r};
        LGAIN_IDX: reg_rdata = {1'b0, left_gain_code_r};
        RGAIN_IDX: reg_rdata = {1'b0, right_gain_code_r};
        default: reg_rdata = 10'h000;
      endcase
    end
  end

  // master clock watchdog: no toggle within the window means the clock stopped;
  // registers are untouched, only the sequencer falls to off
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mclk_q_r <= 1'b0;
      loss_r <= '0;
      mclk_ok_r <= 1'b0;
    end else begin
      mclk_q_r <= mclk_seen;
      if (mclk_q_r != mclk_seen) begin
        loss_r <= '0;
        mclk_ok_r <= 1'b1;
      end else if (loss_r == 10'(MCLK_LOSS_CYC - 1)) begin
        mclk_ok_r <= 1'b0; // R2
      end else begin
        loss_r <= loss_r + 10'h001;
      end
    end
  end
  assign mclk_ok = mclk_ok_r;
  // a stopped clock forces off; restart heads back to the selected state
  assign tgt = mclk_ok ? pwr_sel_t'(power_state_sel_r) : PS_OFF; // R2 R3

  // sequencer: one stage per step, blocks enabled or disabled one at a time
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cur_r <= PS_OFF; // R5
      blk_cnt_r <= '0;
      stage_r <= '0;
    end else if (stage_r != 8'h00) begin
      stage_r <= stage_r - 8'h01;
    end else begin
      case (pwr_sel_t'(cur_r))
        PS_OFF: begin
          blk_cnt_r <= '0; // R11
          if (tgt != PS_OFF) begin
            cur_r <= PS_STANDBY; // R3 R4
            stage_r <= 8'(STAGE_CYC - 1);
          end
        end
        PS_STANDBY: begin
          if (tgt == PS_OFF && blk_cnt_r == '0) begin
            cur_r <= PS_OFF; // R11
          end else if (tgt == PS_OFF || tgt == PS_STANDBY) begin
            if (blk_cnt_r != '0) begin
              blk_cnt_r <= blk_cnt_r - 1'b1; // R10
              stage_r <= 8'(STAGE_CYC - 1);
            end
          end else if (blk_cnt_r != ($bits(blk_cnt_r))'(NUM_BLOCKS)) begin
            blk_cnt_r <= blk_cnt_r + 1'b1; // R7
            stage_r <= 8'(STAGE_CYC - 1);
          end else begin
            cur_r <= PS_MUTED; // R4
          end
        end
        PS_MUTED: begin
          // drop to standby only once the soft mute has fully taken hold; a stopped master clock
          // also stops the samples, so the mute wait is skipped or the fall would hang
          if (tgt == PS_PLAY) begin
            cur_r <= PS_PLAY; // R8
          end else if (tgt != PS_MUTED && (!mclk_ok || (l_att_r == mute_att && r_att_r == mute_att))) begin // R2
            cur_r <= PS_STANDBY; // R4 R10
          end
        end
        PS_PLAY: begin
          if (tgt != PS_PLAY) begin
            cur_r <= PS_MUTED; // R9
          end
        end
        default: cur_r <= PS_OFF;
      endcase
    end
  end

  assign cfg_done = (pwr_sel_t'(cur_r) == PS_MUTED) || (pwr_sel_t'(cur_r) == PS_PLAY);
  assign power_state = cur_r;
  assign clocks_en = (pwr_sel_t'(cur_r) != PS_OFF); // R5
  assign charge_pump_en = (pwr_sel_t'(cur_r) != PS_OFF); // R6 R11
  assign soft_mute = (pwr_sel_t'(cur_r) != PS_PLAY); // R7 R9

  // block enables, one bit per powered block
  for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_blk
    assign block_en[b] = (blk_cnt_r > ($bits(blk_cnt_r))'(b)); // R6 R7 R10
  end

  // attenuation goals: code to 0.125dB units, clamped at +12dB
  function automatic logic [9:0] code_att(input logic [8:0] code);
    logic [8:0] c;
    c = (code >= GAIN_MAX_CODE) ? GAIN_MAX_CODE : code; // R13
    return GAIN_HALF_MAX - {c, 1'b0}; // R13
  endfunction

  assign mute_att = cfg_done ? SOFT_MUTE_ATTEN : STANDBY_ATTEN; // R9 R10
  assign l_goal = soft_mute ? mute_att : code_att(left_tgt_r);
  assign r_goal = soft_mute ? mute_att : code_att(right_tgt_r);

  // zero cross: sign change on either channel since the last sample
  assign zc_hit = (s_l[SAMPLE_W-1] != prev_l_r[SAMPLE_W-1]) ||
                  (s_r[SAMPLE_W-1] != prev_r_r[SAMPLE_W-1]);
  assign zc_force = (zc_cnt_r == ZW'(ZC_TIMEOUT - 1)); // R21

  // zero cross timeout counter, counts samples while a step is pending
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      zc_cnt_r <= '0;
      prev_l_r <= '0;
      prev_r_r <= '0;
    end else if (f_valid && f_ready) begin
      prev_l_r <= s_l;
      prev_r_r <= s_r;
      if ((l_att_r != l_goal || r_att_r != r_goal) && !zc_hit && !zc_force) begin
        zc_cnt_r <= zc_cnt_r + 1'b1; // R21
      end else begin
        zc_cnt_r <= '0;
      end
    end
  end

  // gain engine: advance once per sample, ramp or step per direction
  function automatic logic [9:0] gain_step(input logic [9:0] cur, input logic [9:0] goal,
                                           input logic ramp_up, input logic ramp_dn,
                                           input logic zc_en, input logic zc_ok);
    logic [9:0] nxt;
    nxt = cur;
    if (goal > cur) begin
      // more attenuation means a gain decrease
      if (ramp_dn) begin
        nxt = cur + 10'h001; // R19 R22
      end else if (!zc_en || zc_ok) begin
        nxt = goal; // R20
      end
    end else if (goal < cur) begin
      if (ramp_up) begin
        nxt = cur - 10'h001; // R19 R22
      end else if (!zc_en || zc_ok) begin
        nxt = goal; // R20
      end
    end
    return nxt;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      l_att_r <= STANDBY_ATTEN;
      r_att_r <= STANDBY_ATTEN;
    end else if (!cfg_done) begin
      l_att_r <= STANDBY_ATTEN; // R10
      r_att_r <= STANDBY_ATTEN;
    end else if (f_valid) begin
      // one step per sample gives a ramp rate inverse to sample rate
      l_att_r <= gain_step(l_att_r, l_goal, gain_increase_ramp_en_r, // R18
                           gain_decrease_ramp_en_r, zero_cross_gate_en_r, zc_hit || zc_force);
      r_att_r <= gain_step(r_att_r, r_goal, gain_increase_ramp_en_r,
                           gain_decrease_ramp_en_r, zero_cross_gate_en_r, zc_hit || zc_force);
    end
  end

  // output register: samples pass with the attenuation in force
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_left <= '0;
      out_right <= '0;
      left_atten <= STANDBY_ATTEN;
      right_atten <= STANDBY_ATTEN;
    end else begin
      out_valid <= f_valid && f_ready;
      left_atten <= l_att_r;
      right_atten <= r_att_r;
      if (f_valid && f_ready) begin
        out_left <= s_l;
        out_right <= s_r;
      end
    end
  end
endmodule
`default_nettype wire

// [src/dac_pwr_vol_pkg.sv]
/*
  constants shared by the power state and digital gain block and its bound checker.
  assumes the serial control interface decodes register writes into a word index
  plus 10 bit data and hands them over as one-cycle strobes.
*/
// Summary of operation
// (R1) two-bit power state field, reset off
// (R2) master clock stop forces off, keeps registers
// (R3) clock restart reruns sequence to selected state
// (R4) sequencer steps through intermediate stages automatically
// (R5) off stops clocks, disables all blocks
// (R6) standby runs charge pump and control only
// (R7) state 10 powers blocks sequentially, soft muted
// (R8) state 11 releases soft mute, plays audio
// (R9) 11 to 10 applies 100dB soft mute
// (R10) standby entry powers down sequentially, 120dB attenuation
// (R11) off disables charge pump; restart fully reinitialises
// (R12) per-channel 9-bit gain, reset 190h
// (R13) code 000h is -100dB, 0.25dB steps, clamp
// (R14) update bit applies both gains together
// (R15) gain control only in I2C mode
// (R16) increase ramp bit 1, reset 0
// (R17) decrease ramp bit 0, reset 1
// (R18) ramp rate scales inversely with sample rate
// (R19) ramp uses 0.125dB increments, no zero cross
// (R20) step changes optionally zero-cross gated
// (R21) zero cross timeout 14400 samples forces change
// (R22) ramp advances one increment per sample
package dac_pwr_vol_pkg;
  localparam logic [3:0] PWR_CTRL_IDX = 4'h2;   // power_state_control
  localparam logic [3:0] CTRL3_IDX = 4'h5;      // dac_control_three
  localparam logic [3:0] LGAIN_IDX = 4'h6;      // left_gain
  localparam logic [3:0] RGAIN_IDX = 4'h7;      // right_gain
  localparam int PSEL_LSB = 0;                  // power_state_sel [1:0]
  localparam int DEC_RAMP_BIT = 0;              // gain_decrease_ramp_en
  localparam int INC_RAMP_BIT = 1;              // gain_increase_ramp_en
  localparam int ZC_BIT = 4;                    // zero_cross_gate_en
  localparam int APPLY_BIT = 9;                 // gain apply strobe bit
  localparam logic [1:0] PSEL_RST = 2'h0;
  localparam logic [9:0] CTRL3_RST = 10'h001;
  localparam logic [8:0] GAIN_RST = 9'h190;
  localparam logic [8:0] GAIN_MAX_CODE = 9'h1bf; // 1bfh and above clamp to +12dB
  localparam logic [9:0] GAIN_HALF_MAX = 10'h37e; // code 000h attenuation, 111.75dB in 0.125dB units
  localparam logic [9:0] SOFT_MUTE_ATTEN = 10'h320; // 100dB in 0.125dB units
  localparam logic [9:0] STANDBY_ATTEN = 10'h3c0;   // 120dB in 0.125dB units
  localparam int ZC_TIMEOUT_SAMPLES = 14400;
  localparam int MCLK_LOSS_NS = 2000;           // master clock presence window
  localparam int CLK_NS = 5;
  localparam int MCLK_LOSS_CYC = MCLK_LOSS_NS / CLK_NS;
  localparam int STAGE_CYC = 64;                // per block power step
  localparam int NUM_BLOCKS = 4;                // blocks stepped in sequence
  typedef enum logic [1:0] {PS_OFF, PS_STANDBY, PS_MUTED, PS_PLAY} pwr_sel_t;
endpackage

// [src/sample_fifo.sv]
/*
  small synchronous fifo carrying stereo sample words to the gain stage.
  assumes one clock; full and empty are exact, no overflow is possible
  because in_ready drops when full.
*/
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];   // storage words
  logic [AW-1:0] wr_r;               // write pointer
  logic [AW-1:0] rd_r;               // read pointer
  logic [AW:0] cnt_r;                // fill level
  logic push;
  logic pop;

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rd_r];

  // storage written only, no reset needed for data
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule
`default_nettype wire

// [verification/dac_pwr_vol_props.sv]
/*
  assertions on the power sequencer outputs and the register read port.
  assumes the package constants and one clock, ref_clk, with resetn.
*/
`timescale 1ns/10ps
`default_nettype none
module dac_pwr_vol_props
  import dac_pwr_vol_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reg_rd,
  input wire logic [9:0] reg_rdata,
  input wire logic mclk_seen,
  input wire logic out_valid,
  input wire logic [9:0] left_atten,
  input wire logic clocks_en,
  input wire logic charge_pump_en,
  input wire logic [NUM_BLOCKS-1:0] block_en,
  input wire logic soft_mute,
  input wire logic [1:0] power_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic mclk_q_r; // last seen marker level
  logic [9:0] idle_cnt_r; // cycles since the marker moved, saturating
  // counts how long the master clock has been silent
  always_ff @(posedge ref_clk) begin
    mclk_q_r <= mclk_seen;
    if (!resetn || mclk_seen != mclk_q_r) begin
      idle_cnt_r <= 10'h000;
    end else if (idle_cnt_r != 10'h3ff) begin
      idle_cnt_r <= idle_cnt_r + 10'h001;
    end
  end
  reset_vals_a: assert property (disable iff (1'b0) !resetn |=>
    power_state == 2'h0 && soft_mute && left_atten == 10'h3c0) else $error("reset outputs wrong");
  off_quiet_a: assert property (power_state == 2'h0 |->
    !clocks_en && !charge_pump_en && block_en == '0) else $error("off state not quiet");
  standby_pump_a: assert property (power_state == 2'h1 |->
    charge_pump_en && clocks_en) else $error("standby lost charge pump");
  muted_hold_a: assert property (power_state == 2'h2 |->
    soft_mute && block_en == '1) else $error("muted state wrong");
  play_open_a: assert property (power_state == 2'h3 |->
    !soft_mute && block_en == '1 && clocks_en) else $error("play state wrong");
  step_seq_a: assert property ($changed(power_state) && power_state != 2'h0 |->
    power_state == $past(power_state) + 2'h1 || power_state == $past(power_state) - 2'h1)
    else $error("power state skipped a stage");
  rd_idle_a: assert property (!reg_rd |-> reg_rdata == 10'h000) else $error("read data not idle");
  out_power_a: assert property (out_valid |-> power_state[1] || $past(power_state[1]))
    else $error("sample out while unpowered");
  mclk_loss_a: assert property (idle_cnt_r == 10'h320 |-> power_state == 2'h0)
    else $error("clock loss did not force off");
endmodule
bind dac_power_state_and_volume dac_pwr_vol_props props_inst (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .mclk_seen(mclk_seen),
  .out_valid(out_valid),
  .left_atten(left_atten),
  .clocks_en(clocks_en),
  .charge_pump_en(charge_pump_en),
  .block_en(block_en),
  .soft_mute(soft_mute),
  .power_state(power_state)
);
`default_nettype wire

// [verification/host_ctrl_model.sv]
/*
  host controller model: decoded register writes and reads.
  assumes writes are one-cycle strobes taken on the rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module host_ctrl_model (
  input wire logic ref_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [3:0] reg_idx,
  output logic [9:0] reg_wdata,
  input wire logic [9:0] reg_rdata
);
  // idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_idx = 4'h0;
    reg_wdata = 10'h000;
  end
  // one strobe cycle, launched after a falling edge
  task automatic wr(input logic [3:0] idx, input logic [9:0] data);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_idx = idx;
    reg_wdata = data;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~data; // released data must not look like a stale write
  endtask
  // read data is combinational, taken at the rising edge
  task automatic rd(input logic [3:0] idx, output logic [9:0] data);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_idx = idx;
    @(posedge ref_clk);
    data = reg_rdata;
    @(negedge ref_clk);
    reg_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verification/dac_power_state_and_volume_tb.sv]
/*
  testbench: power sequencing, gain registers, ramps and zero cross.
  assumes host_ctrl_model and the bound checker; zero cross timeout shortened to 16.
*/
`timescale 1ns/10ps
`default_nettype none
module dac_power_state_and_volume_tb;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr, reg_rd, i2c_mode = 1'b1, smp_valid = 1'b0, smp_ready, out_valid;
  logic [3:0] reg_idx;
  logic [9:0] reg_wdata, reg_rdata, left_atten, right_atten, a1, v;
  logic mclk_seen = 1'b0, mclk_on = 1'b1, alt = 1'b1, neg = 1'b0, took = 1'b0;
  logic clocks_en, charge_pump_en, soft_mute;
  logic [3:0] block_en;
  logic [1:0] power_state;
  logic [2:0] gap = 3'h0;
  logic [23:0] smp_left, out_left, out_right;
  int mismatches = 0;
  int n_compared = 0;
  int i;
  assign smp_left = neg ? 24'hff_fc18 : 24'h00_03e8; // sign flips give zero crossings
  // 5 ns clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // master clock marker toggles while the clock runs
  always @(negedge ref_clk) begin
    if (mclk_on) begin
      mclk_seen <= ~mclk_seen;
    end
  end
  always @(posedge ref_clk) begin
    took <= smp_valid && smp_ready;
  end
  // one sample every 8 cycles, held until taken
  always @(negedge ref_clk) begin
    gap <= gap + 3'h1;
    if (took) begin
      smp_valid <= 1'b0;
    end else if (!smp_valid && gap == 3'h0) begin
      smp_valid <= 1'b1;
      neg <= alt && !neg;
    end
  end
  host_ctrl_model host_ctrl_model_inst (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_idx(reg_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  dac_power_state_and_volume #(.ZC_TIMEOUT(16)) dac_power_state_and_volume_inst (
    .ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_idx(reg_idx),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .i2c_mode(i2c_mode), .mclk_seen(mclk_seen),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_left(smp_left), .smp_right(smp_left),
    .out_valid(out_valid), .out_left(out_left), .out_right(out_right), .left_atten(left_atten),
    .right_atten(right_atten), .clocks_en(clocks_en), .charge_pump_en(charge_pump_en),
    .block_en(block_en), .soft_mute(soft_mute), .power_state(power_state));
  task automatic end_of_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] idx, input logic [9:0] exp);
    logic [9:0] d;
    host_ctrl_model_inst.rd(idx, d);
    chk(d, exp);
  endtask
  // bounded wait for a sequencer state; a miss ends the run
  task automatic wait_state(input logic [1:0] ps, input int bound);
    for (int k = 0; k < bound && power_state !== ps; k++) begin
      @(negedge ref_clk);
    end
    if (power_state !== ps) begin
      chk({8'h00, power_state}, {8'h00, ps});
      end_of_test();
    end
  endtask
  // bounded wait for n drained samples
  task automatic wait_smp(input int n);
    int got;
    got = 0;
    for (int k = 0; k < 200 * n && got < n; k++) begin
      @(negedge ref_clk);
      got += (out_valid === 1'b1) ? 1 : 0;
    end
    if (got < n) begin
      chk(10'(got), 10'(n));
      end_of_test();
    end
  endtask
  // true while a ramp sits strictly between its ends
  function automatic logic [9:0] between(input logic [9:0] x, input logic [9:0] lo, input logic [9:0] hi);
    return {9'h000, x > lo && x < hi};
  endfunction
  initial begin
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    rchk(4'h2, 10'h000);
    rchk(4'h5, 10'h001);
    rchk(4'h6, 10'h190);
    rchk(4'h7, 10'h190);
    rchk(4'hf, 10'h000);
    chk(left_atten, 10'h3c0);
    repeat (150) @(negedge ref_clk);
    chk({9'h000, smp_ready}, 10'h000);
    i2c_mode = 1'b0;
    host_ctrl_model_inst.wr(4'h6, 10'h3a0);
    rchk(4'h6, 10'h190);
    i2c_mode = 1'b1;
    host_ctrl_model_inst.wr(4'h2, 10'h003);
    rchk(4'h2, 10'h003);
    wait_state(2'h1, 500);
    chk({6'h00, block_en}, 10'h000);
    wait_state(2'h2, 1000);
    wait_state(2'h3, 500);
    host_ctrl_model_inst.wr(4'h5, 10'h000);
    host_ctrl_model_inst.wr(4'h6, 10'h3bf);
    wait_smp(3);
    a1 = left_atten;
    host_ctrl_model_inst.wr(4'h6, 10'h3ff);
    wait_smp(3);
    chk(left_atten, a1);
    host_ctrl_model_inst.wr(4'h6, 10'h1be);
    rchk(4'h6, 10'h1be);
    wait_smp(3);
    chk(left_atten, a1);
    host_ctrl_model_inst.wr(4'h7, 10'h3be);
    wait_smp(3);
    chk(left_atten, a1 + 10'h002);
    chk(right_atten, a1 + 10'h002);
    host_ctrl_model_inst.wr(4'h5, 10'h001);
    host_ctrl_model_inst.wr(4'h6, 10'h3ae);
    wait_smp(2);
    chk(between(left_atten, a1 + 10'h002, a1 + 10'h022), 10'h001);
    wait_smp(40);
    chk(left_atten, a1 + 10'h022);
    host_ctrl_model_inst.wr(4'h5, 10'h002);
    host_ctrl_model_inst.wr(4'h6, 10'h3be);
    wait_smp(2);
    chk(between(left_atten, a1 + 10'h002, a1 + 10'h022), 10'h001);
    wait_smp(40);
    chk(left_atten, a1 + 10'h002);
    alt = 1'b0;
    host_ctrl_model_inst.wr(4'h5, 10'h010);
    wait_smp(2);
    host_ctrl_model_inst.wr(4'h6, 10'h3ae);
    wait_smp(6);
    chk(left_atten, a1 + 10'h002);
    chk(out_left, 24'h00_03e8);
    chk(out_right, 24'h00_03e8);
    wait_smp(16);
    chk(left_atten, a1 + 10'h022);
    alt = 1'b1;
    host_ctrl_model_inst.wr(4'h2, 10'h002);
    wait_state(2'h2, 500);
    chk({9'h000, soft_mute}, 10'h001);
    host_ctrl_model_inst.wr(4'h2, 10'h001);
    wait_state(2'h1, 3000);
    for (i = 0; i < 2000 && block_en !== 4'h0; i++) begin
      @(negedge ref_clk);
    end
    chk({6'h00, block_en}, 10'h000);
    chk({9'h000, charge_pump_en}, 10'h001);
    chk(left_atten, 10'h3c0);
    host_ctrl_model_inst.wr(4'h2, 10'h003);
    wait_state(2'h3, 3000);
    mclk_on = 1'b0;
    wait_state(2'h0, 1000);
    rchk(4'h2, 10'h003);
    rchk(4'h6, 10'h1ae);
    repeat (200) @(negedge ref_clk);
    chk({8'h00, power_state}, 10'h000);
    mclk_on = 1'b1;
    wait_state(2'h3, 3000);
    host_ctrl_model_inst.wr(4'h2, 10'h000);
    wait_state(2'h0, 3000);
    chk({9'h000, charge_pump_en}, 10'h000);
    end_of_test();
  end
endmodule
`default_nettype wire
